// ### inc/pmr_regs.svh
// Register indices, field positions, reset values and timing counts of the PHY management bank
`ifndef PMR_REGS_SVH
`define PMR_REGS_SVH

`define PMR_IDX_CTRL        5'h00
`define PMR_IDX_STAT        5'h01
`define PMR_IDX_ID_HI       5'h02
`define PMR_IDX_ID_LO       5'h03
`define PMR_IDX_ADV         5'h04
`define PMR_IDX_LPA         5'h05

`define PMR_CTRL_RESET      15
`define PMR_CTRL_LOOP       14
`define PMR_CTRL_SPEED      13
`define PMR_CTRL_AN_EN      12
`define PMR_CTRL_PDOWN      11
`define PMR_CTRL_AN_RST     9
`define PMR_CTRL_DUPLEX     8
`define PMR_CTRL_COL_TEST   7

`define PMR_STAT_AN_DONE    5
`define PMR_STAT_RFAULT     4
`define PMR_STAT_LINK       2
`define PMR_STAT_JABBER     1

`define PMR_CTRL_RST_VAL    16'h3000
`define PMR_STAT_FIXED      16'h7809
`define PMR_ADV_RST_VAL     16'h01E1
`define PMR_ADV_WR_MASK     16'h2DFF
`define PMR_LPA_RO_MASK     16'h6FFF
`define PMR_CTRL_WR_MASK    16'h7B80

`define PMR_SOFT_RST_NS     1000
`define PMR_CLK_NS          8
`define PMR_SOFT_RST_CYC    ((`PMR_SOFT_RST_NS + `PMR_CLK_NS - 1) / `PMR_CLK_NS)

`endif

// ### inc/pmr_pkg.sv
// Types shared by the PHY management bank
package pmr_pkg;
    typedef enum logic [1:0] {
        PMR_RUN   = 2'b00,
        PMR_RESET = 2'b01
    } pmr_state_t;

    typedef enum logic [1:0] {
        PMR_PAUSE_NONE = 2'b00,
        PMR_PAUSE_SYM  = 2'b01,
        PMR_PAUSE_ASYM = 2'b10,
        PMR_PAUSE_BOTH = 2'b11
    } pmr_pause_t;
endpackage

// ### design/pmr_latch_bit.sv
// One latched status bit: holds an event until a read, then follows the live level
`timescale 1ns/1ps
module pmr_latch_bit #(
    parameter bit HOLD_HIGH = 1'b1
) (
    input  wire logic clk,        // Device clock
    input  wire logic rst_n,      // Synchronised reset, active low
    input  wire logic clr,        // Synchronous clear to idle value
    input  wire logic live,       // Current condition
    input  wire logic rd,         // Status register read this cycle
    output logic      value       // Value presented on read
);
    logic held_reg;
    logic held_next;
    wire  logic event_now = (live == HOLD_HIGH);

    // Event wins over the read or clear that would release it
    assign held_next = event_now ? 1'b1 : ((rd || clr) ? 1'b0 : held_reg);
    assign value     = held_reg ? HOLD_HIGH : live;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held_reg <= 1'b0;
        end else begin
            held_reg <= held_next;
        end
    end
endmodule

// ### design/pmr_bank.sv
// PHY management register bank, indices 0 to 5, reached by index from the MAC
//
// Behaviour
// R1: Registers reached only by a five-bit index from MAC management access, not mapped.
// R2: Writing control bit 15 starts soft reset; bit clears itself when reset ends.
// R3: Master sets the reset bit with all other control bits zero.
// R4: After soft reset the PHY returns to normal operating mode.
// R5: Fields kept through soft reset survive only the control-bit reset.
// R6: Autoneg enabled ignores manual speed and duplex; speed 1 means 100 Mbps.
// R7: Master clears autoneg enable before setting power-down bit 11.
// R8: Writing control bit 9 restarts autoneg; bit clears itself afterwards.
// R9: Control bit 7 enables collision test; resets to zero.
// R10: Status reports fixed abilities: no T4, TX and 10T both duplexes, AN, extended.
// R11: Status bit 5 reads one only once autoneg has completed.
// R12: Remote fault bit 4 and jabber bit 1 latch high.
// R13: Link status bit 2 latches low until read; resets to zero.
// R14: Identifier index 2 holds OUI bits 3 to 18.
// R15: Identifier index 3 holds OUI 19 to 24, model and revision.
// R16: Advertised pause field 11:10 uses four-value encoding; resets to 00.
// R17: With both pause modes advertised, at most one is settled after autoneg.
// R18: Advertised ability bits 8 to 5 reset to one; selector resets to 00001.
// R19: Partner next page bit reads zero.
// R20: Partner bit 14 reads one once partner code word is received.
// R21: Partner read-only bits reflect the received code word; reset to zero.
// R22: Latched status bits hold until read, then follow the live condition.
`timescale 1ns/1ps
`include "pmr_regs.svh"
module pmr_bank #(
    parameter logic [15:0] ID_HI_DEFAULT = 16'h1234,  // Arbitrary identifier value
    parameter logic [15:0] ID_LO_DEFAULT = 16'h5678,  // Arbitrary identifier value
    parameter int          RST_CYCLES    = `PMR_SOFT_RST_CYC
) (
    input  wire logic        clk,           // Device clock, 125 MHz
    input  wire logic        arst_n,        // Asynchronous reset, active low
    input  wire logic [4:0]  mgmt_index,    // Register index from MAC access logic
    input  wire logic        mgmt_wr,       // Write strobe, one cycle
    input  wire logic        mgmt_rd,       // Read strobe, one cycle
    input  wire logic [15:0] mgmt_wdata,    // Write data
    output logic      [15:0] mgmt_rdata,    // Read data, registered
    output logic             mgmt_rvalid,   // Read data valid, one cycle
    input  wire logic        link_up,       // Live link condition
    input  wire logic        remote_fault,  // Live remote fault condition
    input  wire logic        jabber,        // Live jabber condition
    input  wire logic        an_complete,   // Autoneg process finished
    input  wire logic        lp_valid,      // Partner code word received pulse
    input  wire logic [15:0] lp_word,       // Received partner code word
    output logic             phy_reset,     // PHY core held in soft reset
    output logic             loopback,      // Loopback mode
    output logic             speed_100,     // Effective manual speed
    output logic             full_duplex,   // Effective manual duplex
    output logic             an_enable,     // Autoneg enabled
    output logic             an_restart,    // Autoneg restart pulse
    output logic             power_down,    // General power down
    output logic             col_test,      // Collision test enable
    output logic [1:0]       pause_result   // Settled pause mode after autoneg
);
    // ==========================================================
    // Reset synchroniser
    logic [1:0] rst_sync_reg;
    wire  logic rst_n = rst_sync_reg[1];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    // ==========================================================
    // Index decode
    function automatic logic hit(input logic [4:0] idx, input logic [4:0] want);
        hit = (idx == want);
    endfunction

    wire logic wr_ctrl  = mgmt_wr && hit(mgmt_index, `PMR_IDX_CTRL);   // R1
    wire logic wr_id_hi = mgmt_wr && hit(mgmt_index, `PMR_IDX_ID_HI);
    wire logic wr_id_lo = mgmt_wr && hit(mgmt_index, `PMR_IDX_ID_LO);
    wire logic wr_adv   = mgmt_wr && hit(mgmt_index, `PMR_IDX_ADV);
    wire logic rd_stat  = mgmt_rd && hit(mgmt_index, `PMR_IDX_STAT);

    // ==========================================================
    // Soft reset sequencer
    pmr_pkg::pmr_state_t state_reg;
    pmr_pkg::pmr_state_t state_next;
    logic [15:0]         rst_cnt_reg;
    logic [15:0]         rst_cnt_next;

    wire logic soft_start = wr_ctrl && mgmt_wdata[`PMR_CTRL_RESET];
    wire logic rst_done   = (state_reg == pmr_pkg::PMR_RESET) && (rst_cnt_reg == 16'h0000);
    wire logic soft_clr   = rst_done;   // R4

    always_comb begin
        state_next   = state_reg;
        rst_cnt_next = rst_cnt_reg;
        unique case (state_reg)
            pmr_pkg::PMR_RUN: begin
                if (soft_start) begin
                    state_next   = pmr_pkg::PMR_RESET;   // R2
                    rst_cnt_next = 16'(RST_CYCLES - 1);
                end
            end
            pmr_pkg::PMR_RESET: begin
                if (rst_cnt_reg == 16'h0000) begin
                    state_next = pmr_pkg::PMR_RUN;       // R2
                end else begin
                    rst_cnt_next = rst_cnt_reg - 16'h0001;
                end
            end
            default: begin
                state_next = pmr_pkg::PMR_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= pmr_pkg::PMR_RUN;
            rst_cnt_reg <= 16'h0000;
        end else begin
            state_reg   <= state_next;
            rst_cnt_reg <= rst_cnt_next;
        end
    end

    assign phy_reset = (state_reg == pmr_pkg::PMR_RESET);

    // ==========================================================
    // Control register
    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic        an_rst_reg;

    // Reset bit shows while sequence runs; restart bit shows for its pulse
    wire logic [15:0] ctrl_view = (ctrl_reg & `PMR_CTRL_WR_MASK & ~(16'h0001 << `PMR_CTRL_AN_RST))
                                | ({15'h0000, phy_reset} << `PMR_CTRL_RESET)
                                | ({15'h0000, an_rst_reg} << `PMR_CTRL_AN_RST);

    assign ctrl_next = soft_clr ? `PMR_CTRL_RST_VAL                          // R4
                     : (wr_ctrl && !soft_start) ? (mgmt_wdata & `PMR_CTRL_WR_MASK)
                     : ctrl_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg   <= `PMR_CTRL_RST_VAL;    // R9
            an_rst_reg <= 1'b0;
        end else begin
            ctrl_reg   <= ctrl_next;
            an_rst_reg <= wr_ctrl && mgmt_wdata[`PMR_CTRL_AN_RST] && !soft_start;   // R8
        end
    end

    assign loopback    = ctrl_reg[`PMR_CTRL_LOOP];
    assign an_enable   = ctrl_reg[`PMR_CTRL_AN_EN];
    assign speed_100   = an_enable ? 1'b1 : ctrl_reg[`PMR_CTRL_SPEED];   // R6
    assign full_duplex = an_enable ? 1'b1 : ctrl_reg[`PMR_CTRL_DUPLEX];  // R6
    assign power_down  = ctrl_reg[`PMR_CTRL_PDOWN];
    assign col_test    = ctrl_reg[`PMR_CTRL_COL_TEST];                   // R9
    assign an_restart  = an_rst_reg;                                     // R8

    // ==========================================================
    // Identifier registers, kept through soft reset
    logic [15:0] id_hi_reg;
    logic [15:0] id_lo_reg;
    logic        rst_sync_done_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            id_hi_reg <= 16'h0000;
            id_lo_reg <= 16'h0000;
        end else if (!rst_sync_done_reg) begin
            id_hi_reg <= ID_HI_DEFAULT;                  // R14
            id_lo_reg <= ID_LO_DEFAULT;                  // R15
        end else begin
            if (wr_id_hi) id_hi_reg <= mgmt_wdata;       // R5
            if (wr_id_lo) id_lo_reg <= mgmt_wdata;       // R5
        end
    end

    // Loads parameter defaults once after release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_done_reg <= 1'b0;
        end else begin
            rst_sync_done_reg <= 1'b1;
        end
    end

    // ==========================================================
    // Advertisement register
    logic [15:0] adv_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adv_reg <= `PMR_ADV_RST_VAL;                              // R18
        end else if (soft_clr) begin
            adv_reg <= `PMR_ADV_RST_VAL;                              // R16
        end else if (wr_adv) begin
            adv_reg <= mgmt_wdata & `PMR_ADV_WR_MASK;
        end
    end

    // ==========================================================
    // Partner ability register
    logic [15:0] lpa_reg;
    logic        lp_ack_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lpa_reg    <= 16'h0000;                                   // R21
            lp_ack_reg <= 1'b0;
        end else if (soft_clr || an_rst_reg) begin
            lpa_reg    <= 16'h0000;
            lp_ack_reg <= 1'b0;
        end else if (lp_valid) begin
            lpa_reg    <= lp_word & `PMR_LPA_RO_MASK & 16'h2FFF;      // R21
            lp_ack_reg <= 1'b1;                                       // R20
        end
    end

    // Next page stays zero, acknowledge from our own flag
    wire logic [15:0] lpa_view = {1'b0, lp_ack_reg, lpa_reg[13:0]};   // R19 R20

    // ==========================================================
    // Pause resolution
    wire logic [1:0] adv_pause = adv_reg[11:10];
    wire logic [1:0] lp_pause  = lpa_reg[11:10];
    logic [1:0] pause_reg;
    logic [1:0] pause_next;

    // Symmetric preferred when both ends offer it, otherwise asymmetric if we advertise it and the partner offers any pause
    assign pause_next = (adv_pause[0] && lp_pause[0]) ? pmr_pkg::PMR_PAUSE_SYM
                      : (adv_pause[1] && lp_pause != 2'b00) ? pmr_pkg::PMR_PAUSE_ASYM
                      : pmr_pkg::PMR_PAUSE_NONE;                       // R16 R17

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pause_reg <= 2'b00;
        end else if (!an_complete || soft_clr) begin
            pause_reg <= 2'b00;
        end else begin
            pause_reg <= pause_next;                                   // R17
        end
    end

    assign pause_result = pause_reg;

    // ==========================================================
    // Status register
    logic fault_v;
    logic jabber_v;
    logic link_v;

    pmr_latch_bit #(.HOLD_HIGH(1'b1)) u_fault (
        .clk   (clk),
        .rst_n (rst_n),
        .clr   (soft_clr),
        .live  (remote_fault),
        .rd    (rd_stat),
        .value (fault_v)
    );  // R12 R22

    pmr_latch_bit #(.HOLD_HIGH(1'b1)) u_jabber (
        .clk   (clk),
        .rst_n (rst_n),
        .clr   (soft_clr),
        .live  (jabber),
        .rd    (rd_stat),
        .value (jabber_v)
    );  // R12 R22

    pmr_latch_bit #(.HOLD_HIGH(1'b0)) u_link (
        .clk   (clk),
        .rst_n (rst_n),
        .clr   (soft_clr),
        .live  (link_up),
        .rd    (rd_stat),
        .value (link_v)
    );  // R13 R22

    wire logic an_done_v = an_enable && an_complete && !phy_reset;     // R11

    wire logic [15:0] stat_view = `PMR_STAT_FIXED                      // R10
                                | ({15'h0000, an_done_v} << `PMR_STAT_AN_DONE)
                                | ({15'h0000, fault_v}   << `PMR_STAT_RFAULT)
                                | ({15'h0000, link_v}    << `PMR_STAT_LINK)
                                | ({15'h0000, jabber_v}  << `PMR_STAT_JABBER);

    // ==========================================================
    // Read path
    logic [15:0] rd_mux;

    always_comb begin
        unique case (mgmt_index)
            `PMR_IDX_CTRL:  rd_mux = ctrl_view;
            `PMR_IDX_STAT:  rd_mux = stat_view;
            `PMR_IDX_ID_HI: rd_mux = id_hi_reg;
            `PMR_IDX_ID_LO: rd_mux = id_lo_reg;
            `PMR_IDX_ADV:   rd_mux = adv_reg;
            `PMR_IDX_LPA:   rd_mux = lpa_view;
            default:        rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mgmt_rdata  <= 16'h0000;
            mgmt_rvalid <= 1'b0;
        end else begin
            mgmt_rvalid <= mgmt_rd;                                    // R1
            if (mgmt_rd) mgmt_rdata <= rd_mux;
        end
    end

    // ==========================================================
    // Checks
    sequence s_soft_start;
        soft_start && state_reg == pmr_pkg::PMR_RUN;
    endsequence

    a_reset_selfclear: assert property (@(posedge clk) disable iff (!rst_n)  // R2
        s_soft_start |=> phy_reset [*1] ##[0:1000] !phy_reset)
        else $error("soft reset did not clear");
    a_reset_defaults: assert property (@(posedge clk) disable iff (!rst_n)  // R4
        soft_clr |=> ctrl_reg == `PMR_CTRL_RST_VAL && adv_reg == `PMR_ADV_RST_VAL)
        else $error("soft reset left stale control");
    a_id_kept: assert property (@(posedge clk) disable iff (!rst_n)  // R5
        soft_clr && !wr_id_hi && !wr_id_lo |=> $stable(id_hi_reg) && $stable(id_lo_reg))
        else $error("identifier lost in soft reset");
    a_manual_ignored: assert property (@(posedge clk) disable iff (!rst_n)  // R6
        an_enable |-> speed_100 && full_duplex)
        else $error("manual speed used under autoneg");
    a_restart_pulse: assert property (@(posedge clk) disable iff (!rst_n)  // R8
        an_restart |=> !an_restart)
        else $error("restart bit did not self clear");
    a_status_fixed: assert property (@(posedge clk) disable iff (!rst_n)  // R10
        mgmt_rvalid && $past(rd_stat) |-> (mgmt_rdata & 16'hF809) == 16'h7809)
        else $error("fixed abilities wrong");
    a_link_low_latch: assert property (@(posedge clk) disable iff (!rst_n || soft_clr)  // R13
        !link_up && !rd_stat ##1 link_up && !rd_stat |-> !link_v)
        else $error("link loss not held");
    a_jabber_latch: assert property (@(posedge clk) disable iff (!rst_n || soft_clr)  // R12
        jabber && !rd_stat ##1 !jabber |-> jabber_v)
        else $error("jabber not latched");
    a_lp_nextpage: assert property (@(posedge clk) disable iff (!rst_n)  // R19
        mgmt_rvalid && $past(mgmt_rd && mgmt_index == `PMR_IDX_LPA) |-> !mgmt_rdata[15])
        else $error("partner next page set");
    a_pause_single: assert property (@(posedge clk) disable iff (!rst_n)  // R17
        pause_result != pmr_pkg::PMR_PAUSE_BOTH)
        else $error("both pause modes settled");
endmodule

// ### verification/pmr_mac_model.sv
// MAC-side management access model reaching the PHY bank by register index
`timescale 1ns/1ps
module pmr_mac_model (
    input  wire logic        clk,          // Device clock
    output logic      [4:0]  mgmt_index,   // Register index
    output logic             mgmt_wr,      // Write strobe
    output logic             mgmt_rd,      // Read strobe
    output logic      [15:0] mgmt_wdata,   // Write data
    input  wire logic [15:0] mgmt_rdata,   // Read data
    input  wire logic        mgmt_rvalid   // Read data valid
);
    initial begin
        mgmt_index = 5'h1F;
        mgmt_wdata = 16'hFFFF;
        mgmt_wr    = 1'b0;
        mgmt_rd    = 1'b0;
    end

    // One write cycle; index and data scramble once the strobe drops
    task automatic put(input logic [4:0] idx, input logic [15:0] d);
        @(posedge clk);
        mgmt_index <= idx;
        mgmt_wdata <= d;
        mgmt_wr    <= 1'b1;
        @(posedge clk);
        mgmt_wr    <= 1'b0;
        mgmt_index <= ~idx;
        mgmt_wdata <= ~d;
    endtask

    // Power-down is only ever set after autoneg has been switched off
    task automatic write_reg(input logic [4:0] idx, input logic [15:0] d);
        if (idx == 5'h00 && d[11]) begin
            put(idx, d & 16'hE5FF);
        end
        put(idx, (idx == 5'h00 && d[11]) ? (d & 16'hEFFF) : d);
    endtask

    task automatic soft_reset();
        put(5'h00, 16'h8000);
    endtask

    task automatic read_reg(input logic [4:0] idx, output logic [15:0] d, output bit ok);
        ok = 1'b0;
        d  = 16'h0000;
        @(posedge clk);
        mgmt_index <= idx;
        mgmt_rd    <= 1'b1;
        @(posedge clk);
        mgmt_rd    <= 1'b0;
        mgmt_index <= ~idx;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(posedge clk);
            if (mgmt_rvalid === 1'b1) begin
                ok = 1'b1;
                d  = mgmt_rdata;
            end
        end
    endtask
endmodule

// ### verification/pmr_bank_tb.sv
// Self-checking bench for the PHY management register bank
`timescale 1ns/1ps
`include "pmr_regs.svh"
module pmr_bank_tb;
    localparam int          RST_CYC = 4;
    localparam logic [15:0] ID_HI   = 16'h4D21;  // Arbitrary identifier value
    localparam logic [15:0] ID_LO   = 16'h9E57;  // Arbitrary identifier value
    logic        clk, arst_n, mgmt_wr, mgmt_rd, mgmt_rvalid, link_up, remote_fault, jabber;
    logic        an_complete, lp_valid, phy_reset, loopback, speed_100, full_duplex;
    logic        an_enable, an_restart, power_down, col_test;
    logic [4:0]  mgmt_index;
    logic [15:0] mgmt_wdata, mgmt_rdata, lp_word, seed, w, e, d;
    logic [1:0]  pause_result;
    int          bad_count, n_tests, restarts, base;
    bit          rd_ok;

    pmr_bank #(.ID_HI_DEFAULT(ID_HI), .ID_LO_DEFAULT(ID_LO), .RST_CYCLES(RST_CYC)) i_pmr_bank (
        .clk(clk), .arst_n(arst_n), .mgmt_index(mgmt_index), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
        .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .link_up(link_up),
        .remote_fault(remote_fault), .jabber(jabber), .an_complete(an_complete), .lp_valid(lp_valid),
        .lp_word(lp_word), .phy_reset(phy_reset), .loopback(loopback), .speed_100(speed_100),
        .full_duplex(full_duplex), .an_enable(an_enable), .an_restart(an_restart),
        .power_down(power_down), .col_test(col_test), .pause_result(pause_result));

    pmr_mac_model i_pmr_mac_model (
        .clk(clk), .mgmt_index(mgmt_index), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
        .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid));

    always #4 clk = ~clk;

    always @(posedge clk) begin
        if (an_restart === 1'b1) begin
            restarts++;
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    function automatic logic [15:0] stat(input logic an, input logic rf, input logic lk, input logic jb);
        return 16'h7809 | {10'h000, an, rf, 1'b0, lk, jb, 1'b0};
    endfunction

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chkb(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [4:0] idx, input logic [15:0] exp);
        bit ok;
        i_pmr_mac_model.read_reg(idx, d, ok);
        if (!ok) begin
            bad_count++;
            $display("FAIL %0t read answer missing", $time);
            complete_run();
        end else begin
            chk(d, exp, "read data");
        end
    endtask

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        {link_up, remote_fault, jabber, an_complete, lp_valid} = 5'h00;
        lp_word = 16'h0000;
        seed = 16'h1458;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge clk);
        // Reset values and an unmapped index
        rd_chk(`PMR_IDX_CTRL, 16'h3000);
        rd_chk(`PMR_IDX_STAT, stat(0, 0, 0, 0));
        rd_chk(`PMR_IDX_ID_HI, ID_HI);
        rd_chk(`PMR_IDX_ID_LO, ID_LO);
        rd_chk(`PMR_IDX_ADV, 16'h01E1);
        rd_chk(`PMR_IDX_LPA, 16'h0000);
        rd_chk(5'h07, 16'h0000);
        // Latching status bits
        link_up <= 1'b1;
        rd_chk(`PMR_IDX_STAT, stat(0, 0, 0, 0));
        rd_chk(`PMR_IDX_STAT, stat(0, 0, 1, 0));
        @(posedge clk);
        {link_up, remote_fault, jabber} <= 3'b011;
        @(posedge clk);
        {link_up, remote_fault, jabber} <= 3'b100;
        rd_chk(`PMR_IDX_STAT, stat(0, 1, 0, 1));
        rd_chk(`PMR_IDX_STAT, stat(0, 0, 1, 0));
        an_complete <= 1'b1;
        rd_chk(`PMR_IDX_STAT, stat(1, 0, 1, 0));
        // Control register: corners then random words
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            w = (i == 0) ? 16'h0000 : (i == 1) ? 16'h2300 : seed & 16'h7FFF;
            e = w & 16'h7980;
            e[12] = e[12] & ~w[11];
            base = restarts;
            i_pmr_mac_model.write_reg(`PMR_IDX_CTRL, w);
            rd_chk(`PMR_IDX_CTRL, e);
            chk(16'(restarts - base), {15'h0000, w[9]}, "restart pulses");
            chkb(speed_100, e[12] | e[13], "speed");
            chkb(full_duplex, e[12] | e[8], "duplex");
            chkb(an_enable, e[12], "autoneg enable");
            chkb(col_test, e[7], "collision test");
            chkb(power_down, e[11], "power down");
            chkb(loopback, e[14], "loopback");
        end
        // Advertisement, identifier and read-only registers
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            i_pmr_mac_model.write_reg(`PMR_IDX_ADV, seed);
            rd_chk(`PMR_IDX_ADV, seed & 16'h2DFF);
            i_pmr_mac_model.write_reg(`PMR_IDX_STAT, seed);
            i_pmr_mac_model.write_reg(`PMR_IDX_LPA, seed);
            i_pmr_mac_model.write_reg(`PMR_IDX_ID_LO, ~seed);
            rd_chk(`PMR_IDX_ID_LO, ~seed);
            rd_chk(`PMR_IDX_LPA, 16'h0000);
        end
        // Partner code word and pause resolution with both modes advertised
        i_pmr_mac_model.write_reg(`PMR_IDX_CTRL, 16'h3000);
        i_pmr_mac_model.write_reg(`PMR_IDX_ADV, 16'h0DE1);
        an_complete <= 1'b0;
        repeat (2) @(posedge clk);
        chk({14'h0000, pause_result}, 16'(pmr_pkg::PMR_PAUSE_NONE), "pause idle");
        an_complete <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            seed = lfsr(seed);
            w = (seed & 16'hF3FF) | (16'(p) << 10);
            @(posedge clk);
            lp_word  <= w;
            lp_valid <= 1'b1;
            @(posedge clk);
            lp_valid <= 1'b0;
            lp_word  <= ~w;
            rd_chk(`PMR_IDX_LPA, (w & 16'h2FFF) | 16'h4000);
            e = p[0] ? 16'(pmr_pkg::PMR_PAUSE_SYM) : (p != 0) ? 16'(pmr_pkg::PMR_PAUSE_ASYM) : 16'h0000;
            chk({14'h0000, pause_result}, e, "pause result");
        end
        // Soft reset keeps identifiers, restores the rest
        i_pmr_mac_model.write_reg(`PMR_IDX_ID_HI, 16'hC3A5);
        i_pmr_mac_model.write_reg(`PMR_IDX_CTRL, 16'h4180);
        i_pmr_mac_model.soft_reset();
        i_pmr_mac_model.read_reg(`PMR_IDX_CTRL, d, rd_ok);
        chkb(rd_ok, 1'b1, "reset read answer");
        chk(d & 16'h8000, 16'h8000, "reset bit");
        chkb(phy_reset, 1'b1, "soft reset active");
        for (int i = 0; i < 40 && phy_reset !== 1'b0; i++) @(posedge clk);
        if (phy_reset !== 1'b0) begin
            bad_count++;
            $display("FAIL %0t soft reset never ended", $time);
            complete_run();
        end
        rd_chk(`PMR_IDX_CTRL, 16'h3000);
        rd_chk(`PMR_IDX_ADV, 16'h01E1);
        rd_chk(`PMR_IDX_ID_HI, 16'hC3A5);
        rd_chk(`PMR_IDX_LPA, 16'h0000);
        chkb(loopback, 1'b0, "loopback after reset");
        // Hardware reset restores identifiers too
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge clk);
        rd_chk(`PMR_IDX_ID_HI, ID_HI);
        complete_run();
    end
endmodule
